/* ipf_defs.svh */
// constants for the interrupt priority field block
`ifndef IPF_DEFS_SVH
`define IPF_DEFS_SVH

// byte offsets of the six priority registers on the apb port
`define IPF_OFF_CTRL4   12'h000
`define IPF_OFF_CTRL5   12'h004
`define IPF_OFF_CTRL6   12'h008
`define IPF_OFF_CTRL7   12'h00C
`define IPF_OFF_CTRL9   12'h010
`define IPF_OFF_CTRL12  12'h014

// register identifiers used by the field table
`define IPF_R4   3'h0
`define IPF_R5   3'h1
`define IPF_R6   3'h2
`define IPF_R7   3'h3
`define IPF_R9   3'h4
`define IPF_R12  3'h5

// field least significant bit positions
`define IPF_POS_HI  12
`define IPF_POS_MH  8
`define IPF_POS_ML  4
`define IPF_POS_LO  0
`define IPF_LANE_SPLIT 8

// field codes
`define IPF_PRIO_RESET 3'h4
`define IPF_PRIO_OFF   3'h0
`define IPF_PRIO_LOW   3'h1
`define IPF_PRIO_TOP   3'h7

`define IPF_NSRC 13
`define IPF_RD_MASK 32'h0000_7777

`endif

/* ipf_pkg.sv */
// types shared by the interrupt priority field block
`default_nettype none
package ipf_pkg;
	typedef logic [2:0] ipf_level_t;
	typedef logic [3:0] ipf_src_t;
	// members run from source 12 down to source 0 so a flat vector casts in order
	typedef struct packed {
		ipf_level_t serial2_event_prio;
		ipf_level_t serial2_collision_prio;
		ipf_level_t timer3_gate_prio;
		ipf_level_t ext_irq2_prio;
		ipf_level_t uart2_rx_prio;
		ipf_level_t uart2_tx_prio;
		ipf_level_t capcmp3_prio;
		ipf_level_t timer4_prio;
		ipf_level_t ext_irq1_prio;
		ipf_level_t serial1_event_prio;
		ipf_level_t serial1_collision_prio;
		ipf_level_t comparator_prio;
		ipf_level_t pin_change_prio;
	} ipf_prio_s;
	typedef struct packed {
		logic       req;
		ipf_level_t level;
		ipf_src_t   source;
	} ipf_irq_s;
endpackage
`default_nettype wire

/* ipf_prio_field.sv */
// one three-bit priority field, optionally absent
`timescale 1ns/1ps
`default_nettype none
`include "ipf_defs.svh"
module ipf_prio_field #(
	parameter bit                 IMPL = 1'b1,
	parameter ipf_pkg::ipf_level_t RST  = `IPF_PRIO_RESET
) (
	input  wire logic                core_clk,
	input  wire logic                rst_b,
	input  wire logic                wr_en,
	input  wire ipf_pkg::ipf_level_t wr_data,
	output logic                     [2:0] level
);
	generate
		if (IMPL) begin : g_impl
			ipf_pkg::ipf_level_t level_reg;
			ipf_pkg::ipf_level_t level_next;
			always_comb begin
				level_next = wr_en ? wr_data : level_reg;
			end
			always_ff @(posedge core_clk) begin
				if (!rst_b) begin
					level_reg <= RST;
				end else begin
					level_reg <= level_next;
				end
			end
			assign level = level_reg;
		end else begin : g_absent
			// absent field: reads zero, writes dropped
			assign level = `IPF_PRIO_OFF;
		end
	endgenerate
endmodule
`default_nettype wire

/* ipf_arbiter.sv */
// picks the pending source with the highest priority level
`timescale 1ns/1ps
`default_nettype none
`include "ipf_defs.svh"
module ipf_arbiter #(
	parameter int NSRC = `IPF_NSRC
) (
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	input  wire logic [NSRC-1:0]   pending,
	input  wire logic [3*NSRC-1:0] prio_flat,
	output ipf_pkg::ipf_irq_s      irq
);
	ipf_pkg::ipf_irq_s   irq_reg;
	ipf_pkg::ipf_irq_s   irq_next;
	ipf_pkg::ipf_level_t best_lvl;
	ipf_pkg::ipf_src_t   best_src;
	logic                any_top;
	logic                any_low;
	logic                any_above_low;
	logic                any_live;
	logic [3*NSRC-1:0]   prio_past_reg;

	always_comb begin
		best_lvl = `IPF_PRIO_OFF;
		best_src = '0;
		any_top = 1'b0;
		any_low = 1'b0;
		any_above_low = 1'b0;
		any_live = 1'b0;
		for (int i = 0; i < NSRC; i++) begin
			// strict compare: code 000 never wins, ties go to lower index
			if (pending[i] && prio_flat[3*i +: 3] > best_lvl) begin
				best_lvl = prio_flat[3*i +: 3];
				best_src = ipf_pkg::ipf_src_t'(i);
			end
			if (pending[i]) begin
				any_top = any_top | (prio_flat[3*i +: 3] == `IPF_PRIO_TOP);
				any_low = any_low | (prio_flat[3*i +: 3] == `IPF_PRIO_LOW);
				any_above_low = any_above_low | (prio_flat[3*i +: 3] > `IPF_PRIO_LOW);
				any_live = any_live | (prio_flat[3*i +: 3] != `IPF_PRIO_OFF);
			end
		end
		irq_next.req = (best_lvl != `IPF_PRIO_OFF);
		irq_next.level = best_lvl;
		irq_next.source = best_src;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			irq_reg <= '0;
			prio_past_reg <= '0;
		end else begin
			irq_reg <= irq_next;
			prio_past_reg <= prio_flat;
		end
	end
	assign irq = irq_reg;

	property p_top_level;
		@(posedge core_clk) disable iff (!rst_b)
		any_top |=> (irq_reg.req && irq_reg.level == `IPF_PRIO_TOP);
	endproperty
	a_top_level: assert property (p_top_level) else $error("code 111 not level 7");

	property p_low_level;
		@(posedge core_clk) disable iff (!rst_b)
		(any_low && !any_above_low) |=> (irq_reg.req && irq_reg.level == `IPF_PRIO_LOW);
	endproperty
	a_low_level: assert property (p_low_level) else $error("code 001 not level 1");

	property p_disabled;
		@(posedge core_clk) disable iff (!rst_b)
		!any_live |=> !irq_reg.req;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled source requested");

	property p_level_is_code;
		@(posedge core_clk) disable iff (!rst_b)
		irq_reg.req |-> (irq_reg.level == prio_past_reg[3*irq_reg.source +: 3]
			&& irq_reg.level != `IPF_PRIO_OFF);
	endproperty
	a_level_is_code: assert property (p_level_is_code) else $error("level not field value");
endmodule
`default_nettype wire

/* ipf_top.sv */
// apb-reached priority registers for thirteen interrupt sources
//
// How it works
// - a field holding 111 gives its source level seven, the highest level.
// - a field holding 001 gives its source level one, the lowest live level.
// - a field holding 000 keeps its source from ever raising a request.
// - bits not holding a field read as zero and ignore writes.
// - after reset every present field holds 100, level four.
// - register 4 holds pin-change priority at 14-12 and comparator at 10-8.
// - register 4 holds serial port 1 collision at 6-4 and event at 2-0.
// - register 5 holds only external interrupt 1 priority at 2-0.
// - register 6 holds timer4 priority at 14-12 and capture/compare 3 at 6-4.
// - register 7 holds uart2 transmit at 14-12, receive at 10-8, ext irq 2 at 6-4.
// - register 9 holds only timer3 gate priority at 6-4.
// - register 12 holds serial port 2 collision at 10-8 and event at 6-4.
// - on the reduced variant the timer4, ccp3, uart2 and serial 2 fields are absent.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ipf_defs.svh"
module ipf_top #(
	parameter bit VARIANT_FULL = 1'b1,
	parameter int ADDR_W       = 12
) (
	input  wire logic               core_clk,
	input  wire logic               rst_b,
	input  wire logic [ADDR_W-1:0]  paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	input  wire logic [`IPF_NSRC-1:0] src_pending,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	output ipf_pkg::ipf_prio_s      prio_o,
	output logic                    irq_req,
	output logic      [2:0]         irq_level,
	output logic      [3:0]         irq_source
);
	localparam int NSRC = `IPF_NSRC;

	// field table, index order matches the struct from the bottom up
	localparam logic [2:0] FREG [NSRC] = '{
		`IPF_R4, `IPF_R4, `IPF_R4, `IPF_R4,
		`IPF_R5,
		`IPF_R6, `IPF_R6,
		`IPF_R7, `IPF_R7, `IPF_R7,
		`IPF_R9,
		`IPF_R12, `IPF_R12
	};
	localparam int FLSB [NSRC] = '{
		`IPF_POS_HI, `IPF_POS_MH, `IPF_POS_ML, `IPF_POS_LO,
		`IPF_POS_LO,
		`IPF_POS_HI, `IPF_POS_ML,
		`IPF_POS_HI, `IPF_POS_MH, `IPF_POS_ML,
		`IPF_POS_ML,
		`IPF_POS_MH, `IPF_POS_ML
	};
	// fields that only the full variant carries
	localparam bit FOPT [NSRC] = '{
		1'b0, 1'b0, 1'b0, 1'b0,
		1'b0,
		1'b1, 1'b1,
		1'b1, 1'b1, 1'b0,
		1'b0,
		1'b1, 1'b1
	};

	logic [31:0]          prdata_reg;
	logic [31:0]          prdata_next;
	logic                 pready_reg;
	logic                 pready_next;
	logic                 pslverr_reg;
	logic                 pslverr_next;
	logic [2:0]           reg_sel;
	logic                 reg_hit;
	logic                 wr_fire;
	logic                 rd_prep;
	logic [15:0]          rd16;
	logic [NSRC-1:0]      field_we;
	logic [3*NSRC-1:0]    prio_flat;
	ipf_pkg::ipf_irq_s    irq;

	// address decode; low address bits must be zero for a hit
	always_comb begin
		reg_sel = `IPF_R4;
		reg_hit = 1'b1;
		case (paddr)
			`IPF_OFF_CTRL4: begin
				reg_sel = `IPF_R4;
			end
			`IPF_OFF_CTRL5: begin
				reg_sel = `IPF_R5;
			end
			`IPF_OFF_CTRL6: begin
				reg_sel = `IPF_R6;
			end
			`IPF_OFF_CTRL7: begin
				reg_sel = `IPF_R7;
			end
			`IPF_OFF_CTRL9: begin
				reg_sel = `IPF_R9;
			end
			`IPF_OFF_CTRL12: begin
				reg_sel = `IPF_R12;
			end
			default: begin
				reg_hit = 1'b0;
			end
		endcase
	end

	// one wait state: pready rises in the second access cycle
	assign wr_fire = psel & penable & pwrite & pready_reg;
	assign rd_prep = psel & penable & ~pready_reg;

	// field write strobes; a lane without its strobe leaves the field alone
	always_comb begin
		for (int i = 0; i < NSRC; i++) begin
			field_we[i] = wr_fire & reg_hit & (reg_sel == FREG[i])
				& pstrb[(FLSB[i] >= `IPF_LANE_SPLIT) ? 1 : 0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi++) begin : g_field
			ipf_prio_field #(
				.IMPL (VARIANT_FULL | !FOPT[gi]),
				.RST  (`IPF_PRIO_RESET)
			) u_field (
				.core_clk (core_clk),
				.rst_b    (rst_b),
				.wr_en    (field_we[gi]),
				.wr_data  (pwdata[FLSB[gi] +: 3]),
				.level    (prio_flat[3*gi +: 3])
			);
		end
	endgenerate

	// read mux builds only field bits, so every other bit is zero
	always_comb begin
		rd16 = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (reg_sel == FREG[i]) begin
				rd16[FLSB[i] +: 3] = prio_flat[3*i +: 3];
			end
		end
	end

	always_comb begin
		pready_next = rd_prep;
		pslverr_next = rd_prep & ~reg_hit;
		prdata_next = prdata_reg;
		if (rd_prep && !pwrite) begin
			prdata_next = reg_hit ? {{16{1'b0}}, rd16} : '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	ipf_arbiter #(
		.NSRC (NSRC)
	) u_arb (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.pending   (src_pending),
		.prio_flat (prio_flat),
		.irq       (irq)
	);

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prio_o = ipf_pkg::ipf_prio_s'(prio_flat);
	assign irq_req = irq.req;
	assign irq_level = irq.level;
	assign irq_source = irq.source;

	property p_read_zeros;
		@(posedge core_clk) disable iff (!rst_b)
		pready_reg |-> ((prdata_reg & ~`IPF_RD_MASK) == '0);
	endproperty
	a_read_zeros: assert property (p_read_zeros) else $error("unassigned bit read nonzero");

	// reset is synchronous, so this one may not be disabled by it
	property p_reset_value;
		@(posedge core_clk)
		!rst_b |=> (prio_o.pin_change_prio == `IPF_PRIO_RESET
			&& prio_o.ext_irq1_prio == `IPF_PRIO_RESET
			&& prio_o.timer3_gate_prio == `IPF_PRIO_RESET);
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("field not 100 after reset");

	property p_ctrl4_hi;
		@(posedge core_clk) disable iff (!rst_b)
		(wr_fire && paddr == `IPF_OFF_CTRL4 && pstrb[1])
			|=> (prio_o.pin_change_prio == $past(pwdata[14:12])
			&& prio_o.comparator_prio == $past(pwdata[10:8]));
	endproperty
	a_ctrl4_hi: assert property (p_ctrl4_hi) else $error("register 4 upper fields wrong");

	property p_ctrl4_lo;
		@(posedge core_clk) disable iff (!rst_b)
		(wr_fire && paddr == `IPF_OFF_CTRL4 && pstrb[0])
			|=> (prio_o.serial1_collision_prio == $past(pwdata[6:4])
			&& prio_o.serial1_event_prio == $past(pwdata[2:0]));
	endproperty
	a_ctrl4_lo: assert property (p_ctrl4_lo) else $error("register 4 lower fields wrong");

	property p_ctrl5;
		@(posedge core_clk) disable iff (!rst_b)
		(wr_fire && paddr == `IPF_OFF_CTRL5 && pstrb[0])
			|=> prio_o.ext_irq1_prio == $past(pwdata[2:0]);
	endproperty
	a_ctrl5: assert property (p_ctrl5) else $error("register 5 field wrong");

	property p_ctrl9_keep;
		@(posedge core_clk) disable iff (!rst_b)
		!(wr_fire && paddr == `IPF_OFF_CTRL9) |=> $stable(prio_o.timer3_gate_prio);
	endproperty
	a_ctrl9_keep: assert property (p_ctrl9_keep) else $error("timer3 gate field changed");

	property p_reduced_absent;
		@(posedge core_clk) disable iff (!rst_b)
		!VARIANT_FULL |-> (prio_o.timer4_prio == '0 && prio_o.uart2_tx_prio == '0
			&& prio_o.serial2_event_prio == '0);
	endproperty
	a_reduced_absent: assert property (p_reduced_absent) else $error("absent field nonzero");

	// optional-field checks only mean something on the full variant
	property p_ctrl6;
		@(posedge core_clk) disable iff (!rst_b)
		(VARIANT_FULL && wr_fire && paddr == `IPF_OFF_CTRL6 && pstrb[1] && pstrb[0])
			|=> (prio_o.timer4_prio == $past(pwdata[14:12])
			&& prio_o.capcmp3_prio == $past(pwdata[6:4]));
	endproperty
	a_ctrl6: assert property (p_ctrl6) else $error("register 6 fields wrong");

	property p_ctrl7_hi;
		@(posedge core_clk) disable iff (!rst_b)
		(VARIANT_FULL && wr_fire && paddr == `IPF_OFF_CTRL7 && pstrb[1])
			|=> (prio_o.uart2_tx_prio == $past(pwdata[14:12])
			&& prio_o.uart2_rx_prio == $past(pwdata[10:8]));
	endproperty
	a_ctrl7_hi: assert property (p_ctrl7_hi) else $error("register 7 upper fields wrong");

	property p_ctrl7_lo;
		@(posedge core_clk) disable iff (!rst_b)
		(wr_fire && paddr == `IPF_OFF_CTRL7 && pstrb[0])
			|=> prio_o.ext_irq2_prio == $past(pwdata[6:4]);
	endproperty
	a_ctrl7_lo: assert property (p_ctrl7_lo) else $error("register 7 lower field wrong");

	property p_ctrl9_write;
		@(posedge core_clk) disable iff (!rst_b)
		(wr_fire && paddr == `IPF_OFF_CTRL9 && pstrb[0])
			|=> prio_o.timer3_gate_prio == $past(pwdata[6:4]);
	endproperty
	a_ctrl9_write: assert property (p_ctrl9_write) else $error("register 9 field wrong");

	property p_ctrl12;
		@(posedge core_clk) disable iff (!rst_b)
		(VARIANT_FULL && wr_fire && paddr == `IPF_OFF_CTRL12 && pstrb[1] && pstrb[0])
			|=> (prio_o.serial2_collision_prio == $past(pwdata[10:8])
			&& prio_o.serial2_event_prio == $past(pwdata[6:4]));
	endproperty
	a_ctrl12: assert property (p_ctrl12) else $error("register 12 fields wrong");

	// a refused write must leave every field as it was
	property p_unmapped_keep;
		@(posedge core_clk) disable iff (!rst_b)
		(wr_fire && !reg_hit) |=> $stable(prio_o);
	endproperty
	a_unmapped_keep: assert property (p_unmapped_keep) else $error("unmapped write changed a field");

	c_write4: cover property (@(posedge core_clk) disable iff (!rst_b)
		wr_fire && paddr == `IPF_OFF_CTRL4);
	c_unmapped: cover property (@(posedge core_clk) disable iff (!rst_b)
		pready_reg && pslverr_reg);
	c_top_req: cover property (@(posedge core_clk) disable iff (!rst_b)
		irq_req && irq_level == `IPF_PRIO_TOP);
	c_half_lane: cover property (@(posedge core_clk) disable iff (!rst_b)
		wr_fire && reg_hit && (pstrb[1] != pstrb[0]));
endmodule
`default_nettype wire

/* tb_ipf_top.sv */
// self-checking bench for the apb priority field block, full and reduced variants
`timescale 1ns/1ps
`default_nettype none
`include "ipf_defs.svh"
module tb_ipf_top;
	typedef struct {
		logic        rd;
		logic [31:0] d;
		logic [31:0] dr;
		logic        err;
	} ipf_note_s;
	logic               core_clk;
	logic               rst_b;
	logic [11:0]        paddr;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [31:0]        pwdata;
	logic [3:0]         pstrb;
	logic [12:0]        src_pending;
	logic [31:0]        prdata;
	logic [31:0]        prdata_r;
	logic               pready;
	logic               pslverr;
	ipf_pkg::ipf_prio_s prio_o;
	ipf_pkg::ipf_prio_s prio_r;
	logic               irq_req;
	logic [2:0]         irq_level;
	logic [3:0]         irq_source;
	int                 error_cnt = 0;
	int                 compares = 0;
	int                 cyc = 0;
	logic [31:0]        lfsr_q = 32'h0000_1536;
	logic [31:0]        r;
	ipf_note_s          notes[$];
	ipf_note_s          mon_note;
	logic [15:0]        img [6];
	logic [15:0]        fmask [6] = '{16'h7777, 16'h0007, 16'h7070, 16'h7770, 16'h0070, 16'h0770};
	logic [15:0]        rmask [6] = '{16'h7777, 16'h0007, 16'h0000, 16'h0070, 16'h0070, 16'h0000};
	logic [11:0]        offs [6] = '{`IPF_OFF_CTRL4, `IPF_OFF_CTRL5, `IPF_OFF_CTRL6,
		`IPF_OFF_CTRL7, `IPF_OFF_CTRL9, `IPF_OFF_CTRL12};

	ipf_top #(.VARIANT_FULL(1'b1), .ADDR_W(12)) i_ipf_top (.core_clk(core_clk), .rst_b(rst_b),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(pstrb), .src_pending(src_pending), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .prio_o(prio_o), .irq_req(irq_req), .irq_level(irq_level),
		.irq_source(irq_source));
	// reduced variant shares the bus; its own handshake matches the full one
	ipf_top #(.VARIANT_FULL(1'b0), .ADDR_W(12)) i_ipf_top_red (.core_clk(core_clk),
		.rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pstrb(pstrb), .src_pending(src_pending), .prdata(prdata_r),
		.pready(), .pslverr(), .prio_o(prio_r), .irq_req(), .irq_level(), .irq_source());

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	function automatic logic [31:0] rnd();
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return lfsr_q;
	endfunction

	function automatic logic [38:0] exp_prio(input bit red);
		logic [15:0] m [6];
		for (int i = 0; i < 6; i++) m[i] = red ? (img[i] & rmask[i]) : img[i];
		return {m[5][6:4], m[5][10:8], m[4][6:4], m[3][6:4], m[3][10:8], m[3][14:12],
			m[2][6:4], m[2][14:12], m[1][2:0], m[0][2:0], m[0][6:4], m[0][10:8], m[0][14:12]};
	endfunction

	// strict greater keeps ties on the lowest index; level 0 never beats the empty start
	function automatic logic [7:0] arb(input logic [12:0] p, input logic [38:0] pr);
		logic [2:0] bl;
		logic [3:0] bs;
		bl = 3'h0;
		bs = 4'h0;
		for (int i = 0; i < 13; i++) if (p[i] && pr[3*i+:3] > bl) begin
			bl = pr[3*i+:3];
			bs = i[3:0];
		end
		return {bl != 3'h0, bl, bs};
	endfunction

	task automatic cmp_bus(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t bus got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_prio(input logic [38:0] got, input logic [38:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t prio got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_irq(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t irq got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [31:0] e, input logic [31:0] er, input logic err);
		notes.push_back('{rd: !wr, d: e, dr: er, err: err});
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= wr;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr_reg(input int i, input logic [31:0] d, input logic [3:0] s);
		logic [15:0] lm;
		lm = {{8{s[1]}}, {8{s[0]}}};
		apb(1'b1, offs[i], d, s, 32'h0, 32'h0, 1'b0);
		img[i] = (img[i] & ~lm) | (d[15:0] & lm & fmask[i]);
	endtask

	task automatic rd_reg(input int i);
		apb(1'b0, offs[i], 32'h0, 4'h0, {16'h0, img[i]}, {16'h0, img[i] & rmask[i]}, 1'b0);
		cmp_prio(prio_o, exp_prio(1'b0));
		cmp_prio(prio_r, exp_prio(1'b1));
	endtask

	task automatic rd_all();
		for (int i = 0; i < 6; i++) rd_reg(i);
	endtask

	task automatic arb_check(input logic [12:0] p);
		@(posedge core_clk);
		src_pending <= p;
		// one cycle for the arbiter to register, one to sample its result
		repeat (2) @(posedge core_clk);
		cmp_irq({irq_req, irq_level, irq_source}, arb(p, exp_prio(1'b0)));
	endtask

	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 6; i++) img[i] = fmask[i] & {4{1'b0, `IPF_PRIO_RESET}};
	endtask

	task print_verdict();
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		if (rst_b === 1'b1 && psel && penable && pready === 1'b1) begin
			mon_note = notes.pop_front();
			cmp_bus({31'h0, pslverr}, {31'h0, mon_note.err});
			if (mon_note.rd) begin
				cmp_bus(prdata, mon_note.d);
				cmp_bus(prdata_r, mon_note.dr);
			end
		end
	end

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end

	initial begin
		rst_b = 1'b0;
		paddr = 12'h000;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
		src_pending = 13'h0000;
		do_reset();
		rd_all();
		arb_check(13'h1fff);
		$display("test reset values done");
		for (int i = 0; i < 6; i++) wr_reg(i, 32'hffff_ffff, 4'hf);
		rd_all();
		arb_check(13'h1fff);
		arb_check(13'h0a00);
		$display("test all ones done");
		for (int i = 0; i < 6; i++) wr_reg(i, 32'h0000_0000, 4'hf);
		rd_all();
		arb_check(13'h1fff);
		wr_reg(1, 32'h0000_0001, 4'hf);
		arb_check(13'h1fff);
		$display("test disable and lowest level done");
		// unmapped places must refuse and leave every field alone
		apb(1'b1, 12'h018, 32'hffff_ffff, 4'hf, 32'h0, 32'h0, 1'b1);
		apb(1'b0, 12'h018, 32'h0, 4'h0, 32'h0, 32'h0, 1'b1);
		apb(1'b0, 12'hffc, 32'h0, 4'h0, 32'h0, 32'h0, 1'b1);
		rd_all();
		$display("test unmapped done");
		for (int n = 0; n < 40; n++) begin
			r = rnd();
			wr_reg(int'(r[18:16]) % 6, rnd(), r[3:0]);
			rd_reg(int'(r[18:16]) % 6);
			r = rnd();
			arb_check(r[12:0]);
		end
		$display("test random fields and arbitration done");
		do_reset();
		rd_all();
		$display("test second reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
